/* File: verilog/omb_regs.vh */
`ifndef OMB_REGS_VH
`define OMB_REGS_VH

// Register byte offsets
`define OMB_CTRL_OFS 8'h00
`define OMB_STAT_OFS 8'h04
`define OMB_IRQ_STAT_OFS 8'h08
`define OMB_IRQ_MASK_OFS 8'h0C
`define OMB_RX_OFS 8'h10

// CTRL fields
`define OMB_CTRL_PS_EN 0
`define OMB_CTRL_PS_LO 1
`define OMB_CTRL_PS_HI 2
`define OMB_CTRL_TM_EN 3
`define OMB_CTRL_CS_EN 4
`define OMB_CTRL_CSO 5
`define OMB_CTRL_UA_EN 6
`define OMB_CTRL_RST 32'h0000_0006

// Interrupt status fields
`define OMB_IRQ_MF 0
`define OMB_IRQ_ALARM_CHG 1
`define OMB_IRQ_REQ_CHG 2
`define OMB_IRQ_W 3

// Multiframe geometry
`define OMB_FRAMES 4'h8
`define OMB_FN_PS1 3'h1
`define OMB_FN_PS2 3'h2
`define OMB_FN_TM 3'h3
`define OMB_FN_CS 3'h4
`define OMB_FN_UA 3'h6
`define OMB_FN_AL 3'h7

`endif

/* File: verilog/omb_overhead_maint.v */
// Operation
// - Power status bits in frames two, three
// - Power codes 11,10,01,00 as defined
// - Unused power status sends ones
// - Test mode bit frame four, zero active
// - Local maintenance on D/B sets test
// - Unused test mode sends one
// - Cold start bit frame five
// - Activity flag frame seven from user signals
// - Unused activity flag sends one
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "omb_regs.vh"

module omb_overhead_maint (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Line framing
    input wire frame_start,
    input wire multiframe_start,
    input wire rx_fourth_overhead_bit,
    output reg tx_fourth_overhead_bit,
    input wire terminal_sync_state_signal,
    input wire line_sync_state,
    // Local status
    input wire d_maint_local,
    input wire b1_maint_local,
    input wire b2_maint_local,
    input wire user_activation_request_signal,
    input wire user_sync_frame_signal,
    // Results
    output reg user_activation_request_rx,
    output reg transmission_alarm_rx,
    output wire irq
);

    reg [31:0] ctrl_r;
    reg [2:0] frame_num_r;
    reg [1:0] ps_hold_r;
    reg tm_hold_r;
    reg ua_hold_r;
    reg cso_hold_r;
    reg uareq_acc_r;
    reg alarm_acc_r;
    reg [`OMB_IRQ_W-1:0] irq_stat_r;
    reg [`OMB_IRQ_W-1:0] irq_mask_r;
    reg [7:0] awaddr_r;
    reg aw_have_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg w_have_r;

    wire wr_go;
    wire rd_go;
    wire [`OMB_IRQ_W-1:0] ev;
    wire test_mode;
    wire activity;
    wire mf_end;
    wire in_ssig;
    wire ua_slot;
    wire al_slot;
    reg tx_bit;

    // Byte-lane merge of a 32-bit register
    function [31:0] lane_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            lane_merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    // Word-aligned register offset; the two low address bits are ignored
    function [7:0] word_ofs;
        input [7:0] addr;
        begin
            word_ofs = {addr[7:2], 2'b00};
        end
    endfunction

    // True on the frame_start that opens frame fn; the counter still shows the frame before
    function starts_frame;
        input [2:0] fn;
        input [2:0] cur;
        input fs;
        input mfs;
        begin
            if (mfs) begin
                starts_frame = fs && fn == 3'h0;
            end else begin
                starts_frame = fs && fn == cur + 3'h1;
            end
        end
    endfunction

    // Write address and data may arrive in either order
    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = !w_have_r && !s_axi_bvalid;
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (word_ofs(awaddr_r))
                    `OMB_CTRL_OFS, `OMB_IRQ_STAT_OFS, `OMB_IRQ_MASK_OFS: begin
                        s_axi_bresp <= 2'h0;
                    end
                    default: begin
                        s_axi_bresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read data is registered; arready stays low until the answer is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (word_ofs(s_axi_araddr))
                `OMB_CTRL_OFS: s_axi_rdata <= ctrl_r;
                `OMB_STAT_OFS: s_axi_rdata <= {27'h0, frame_num_r, test_mode, activity};
                `OMB_IRQ_STAT_OFS: s_axi_rdata <= {29'h0, irq_stat_r};
                `OMB_IRQ_MASK_OFS: s_axi_rdata <= {29'h0, irq_mask_r};
                `OMB_RX_OFS: s_axi_rdata <= {30'h0, transmission_alarm_rx, user_activation_request_rx};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `OMB_CTRL_RST;
        end else if (wr_go && word_ofs(awaddr_r) == `OMB_CTRL_OFS) begin
            ctrl_r <= lane_merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_007F;
        end
    end

    // Mask lives in byte 0; a write without that lane leaves it alone
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_r <= {`OMB_IRQ_W{1'b0}};
        end else if (wr_go && word_ofs(awaddr_r) == `OMB_IRQ_MASK_OFS && wstrb_r[0]) begin
            irq_mask_r <= wdata_r[`OMB_IRQ_W-1:0];
        end
    end

    // Frame counter; power, test mode and activity bits are transmitted in the synchronized state only
    assign mf_end = frame_start && frame_num_r == `OMB_FN_AL;
    assign ua_slot = starts_frame(`OMB_FN_UA, frame_num_r, frame_start, multiframe_start);
    assign al_slot = starts_frame(`OMB_FN_AL, frame_num_r, frame_start, multiframe_start);
    always @(posedge aclk) begin
        if (!aresetn) begin
            frame_num_r <= 3'h0;
        end else if (multiframe_start) begin
            frame_num_r <= 3'h0;
        end else if (frame_start) begin
            frame_num_r <= frame_num_r + 3'h1;
        end
    end

    assign test_mode = d_maint_local | b1_maint_local | b2_maint_local;
    assign activity = user_activation_request_signal | user_sync_frame_signal;
    assign in_ssig = terminal_sync_state_signal;

    // Each setting is snapped at multiframe start so its bit is stable for a whole multiframe
    always @(posedge aclk) begin
        if (!aresetn) begin
            ps_hold_r <= 2'b11;
        end else if (multiframe_start) begin
            ps_hold_r <= (ctrl_r[`OMB_CTRL_PS_EN] && in_ssig) ?
                ctrl_r[`OMB_CTRL_PS_HI:`OMB_CTRL_PS_LO] : 2'b11;
        end
    end

    // Outside the synchronized state the flag idles at one, as if unused
    always @(posedge aclk) begin
        if (!aresetn) begin
            tm_hold_r <= 1'b1;
        end else if (multiframe_start) begin
            tm_hold_r <= (ctrl_r[`OMB_CTRL_TM_EN] && in_ssig) ? !test_mode : 1'b1;
        end
    end

    // Activity from either user signal, one when the function is off
    always @(posedge aclk) begin
        if (!aresetn) begin
            ua_hold_r <= 1'b1;
        end else if (multiframe_start) begin
            ua_hold_r <= (ctrl_r[`OMB_CTRL_UA_EN] && in_ssig) ? activity : 1'b1;
        end
    end

    // Start-up capability is a fixed property, so it ignores the sync state
    always @(posedge aclk) begin
        if (!aresetn) begin
            cso_hold_r <= 1'b0;
        end else if (multiframe_start) begin
            cso_hold_r <= ctrl_r[`OMB_CTRL_CS_EN] && ctrl_r[`OMB_CTRL_CSO];
        end
    end

    always @* begin
        case (frame_num_r)
            `OMB_FN_PS1: begin
                tx_bit = ps_hold_r[1];
            end
            `OMB_FN_PS2: begin
                tx_bit = ps_hold_r[0];
            end
            `OMB_FN_TM: begin
                tx_bit = tm_hold_r;
            end
            `OMB_FN_CS: begin
                tx_bit = cso_hold_r;
            end
            `OMB_FN_UA: begin
                tx_bit = ua_hold_r;
            end
            // Frames without a bit of ours idle at one
            default: begin
                tx_bit = 1'b1;
            end
        endcase
    end

    // Registered so the line sees a clean bit one cycle after the counter moves
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_fourth_overhead_bit <= 1'b1;
        end else begin
            tx_fourth_overhead_bit <= tx_bit;
        end
    end

    // Received bits are taken as their own frame opens; line idles them at one when unused
    always @(posedge aclk) begin
        if (!aresetn) begin
            uareq_acc_r <= 1'b1;
        end else if (ua_slot) begin
            uareq_acc_r <= rx_fourth_overhead_bit;
        end
    end

    // A line out of sync forces the alarm low whatever the bit says
    always @(posedge aclk) begin
        if (!aresetn) begin
            alarm_acc_r <= 1'b1;
        end else if (al_slot) begin
            alarm_acc_r <= rx_fourth_overhead_bit && line_sync_state;
        end
    end

    // Results move only at the multiframe boundary
    always @(posedge aclk) begin
        if (!aresetn) begin
            user_activation_request_rx <= 1'b1;
            transmission_alarm_rx <= 1'b1;
        end else if (mf_end) begin
            user_activation_request_rx <= uareq_acc_r;
            transmission_alarm_rx <= alarm_acc_r;
        end
    end

    // Events: set wins over write-one-to-clear
    assign ev[`OMB_IRQ_MF] = mf_end;
    assign ev[`OMB_IRQ_ALARM_CHG] = mf_end && (alarm_acc_r != transmission_alarm_rx);
    assign ev[`OMB_IRQ_REQ_CHG] = mf_end && (uareq_acc_r != user_activation_request_rx);

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= {`OMB_IRQ_W{1'b0}};
        end else if (wr_go && word_ofs(awaddr_r) == `OMB_IRQ_STAT_OFS && wstrb_r[0]) begin
            irq_stat_r <= (irq_stat_r & ~wdata_r[`OMB_IRQ_W-1:0]) | ev;
        end else begin
            irq_stat_r <= irq_stat_r | ev;
        end
    end

    // Level output: stays high until software clears every unmasked bit
    assign irq = |(irq_stat_r & irq_mask_r);

endmodule // omb_overhead_maint
`default_nettype wire

/* File: testbench/omb_overhead_maint_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module omb_overhead_maint_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line framing
    input wire logic frame_start,
    input wire logic multiframe_start,
    input wire logic tx_fourth_overhead_bit,
    input wire logic user_activation_request_rx,
    input wire logic transmission_alarm_rx
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answering");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read answer");
    a_frame0_ones: assert property (multiframe_start |-> ##2 tx_fourth_overhead_bit)
        else $error("frame 0 bit low");
    a_tx_on_frame: assert property ($changed(tx_fourth_overhead_bit) |-> $past(frame_start) || $past(frame_start, 2))
        else $error("tx bit moved mid frame");
    a_rx_on_frame: assert property ($changed({user_activation_request_rx, transmission_alarm_rx}) |->
        $past(frame_start) || $past(frame_start, 2)) else $error("rx result moved mid frame");
endmodule // omb_overhead_maint_checker
bind omb_overhead_maint omb_overhead_maint_checker i_chk (.*);
`default_nettype wire

/* File: testbench/omb_lt_model.sv */
`timescale 1ns/1ps
`default_nettype none
module omb_lt_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bits to send
    input wire logic lt_req,
    input wire logic lt_alarm,
    // Line side
    input wire logic tx_fourth_overhead_bit,
    output logic frame_start,
    output logic multiframe_start,
    output logic rx_fourth_overhead_bit,
    output logic [7:0] tx_word
);
    logic [5:0] cyc_r;
    logic [7:0] acc_r;
    assign frame_start = aresetn && cyc_r[2:0] == 3'h0;
    assign multiframe_start = aresetn && cyc_r == 6'h0;
    // Other frames toggle so a stray sample cannot pass
    assign rx_fourth_overhead_bit = cyc_r[5:3] == 3'h6 ? lt_req :
        cyc_r[5:3] == 3'h7 ? lt_alarm : cyc_r[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_r <= 6'h0;
            tx_word <= 8'hFF;
        end else begin
            cyc_r <= cyc_r + 6'h1;
            if (cyc_r[2:0] == 3'h4) acc_r[cyc_r[5:3]] <= tx_fourth_overhead_bit;
            if (cyc_r == 6'h3F) tx_word <= acc_r;
        end
    end
endmodule // omb_lt_model
`default_nettype wire

/* File: testbench/omb_overhead_maint_test.sv */
`timescale 1ns/1ps
`default_nettype none
module omb_overhead_maint_test;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, frame_start, multiframe_start, irq;
    logic rx_fourth_overhead_bit, tx_fourth_overhead_bit, terminal_sync_state_signal, line_sync_state;
    logic d_maint_local, b1_maint_local, b2_maint_local, user_activation_request_signal, user_sync_frame_signal;
    logic user_activation_request_rx, transmission_alarm_rx, lt_req, lt_alarm, ok;
    logic [7:0] s_axi_awaddr, s_axi_araddr, tx_word;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    int n_errors = 0, compares = 0, i;
    omb_overhead_maint i_dut (.*);
    omb_lt_model i_lt (.*);
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Handshakes are judged at the falling edge, where ready has settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        ok = 1'h0;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            ok = s_axi_bvalid === 1'h1;
            rr = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (ok) s_axi_bready <= 1'h0;
        end
        if (!ok) begin
            n_errors++;
            tally_and_finish;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic ar;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        ok = 1'h0;
        for (int n = 0; n < 50 && !ok; n++) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            ok = s_axi_rvalid === 1'h1;
            {rv, rr} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'h0;
            if (ok) s_axi_rready <= 1'h0;
        end
        if (!ok) begin
            n_errors++;
            tally_and_finish;
        end
    endtask
    // Two multiframes: one to take new settings, one sent whole
    task automatic mf;
        int k = 2;
        for (int n = 0; n < 300 && k > 0; n++) begin
            @(negedge aclk);
            if (multiframe_start) k--;
        end
        if (k > 0) begin
            n_errors++;
            tally_and_finish;
        end
        // Results latch at the boundary edge; look one edge later, once settled
        repeat (2) @(posedge aclk);
    endtask
    task automatic s_regs;
        rd(8'h00);
        chk(rv, 32'h6);
        rd(8'h14);
        chk({rv[29:0], rr}, 32'h2);
        wr(8'h14, 32'h0);
        chk(rr, 32'h2);
        wr(8'h00, 32'h6);
        chk(rr, 32'h0);
    endtask
    task automatic s_power;
        for (i = 0; i < 4; i++) begin
            wr(8'h00, 32'h1 | i << 1);
            mf;
            chk({tx_word[1], tx_word[2]}, i);
        end
    endtask
    task automatic s_unused;
        d_maint_local <= 1'h1;
        wr(8'h00, 32'h0);
        mf;
        chk(tx_word & 8'hCF, 8'hCF);
        wr(8'h00, 32'h49);
        terminal_sync_state_signal <= 1'h0;
        mf;
        chk(tx_word & 8'hCF, 8'hCF);
        {terminal_sync_state_signal, d_maint_local} <= 2'h2;
    endtask
    task automatic s_test_mode;
        wr(8'h00, 32'hE);
        for (i = 0; i < 4; i++) begin
            {d_maint_local, b1_maint_local, b2_maint_local} <= 3'h4 >> i;
            mf;
            chk(tx_word[3], i == 3);
        end
    endtask
    task automatic s_start_activity;
        wr(8'h00, 32'h36);
        mf;
        chk(tx_word[4], 1'h1);
        wr(8'h00, 32'h56);
        for (i = 0; i < 3; i++) begin
            {user_activation_request_signal, user_sync_frame_signal} <= 2'h2 >> i;
            mf;
            chk({tx_word[4], tx_word[6]}, i < 2);
        end
    endtask
    task automatic s_receive;
        wr(8'h0C, 32'h2);
        wr(8'h08, 32'h7);
        {lt_req, lt_alarm} <= 2'h1;
        mf;
        chk({user_activation_request_rx, transmission_alarm_rx}, 2'h1);
        chk(irq, 1'h0);
        rd(8'h10);
        chk(rv, 32'h2);
        line_sync_state <= 1'h0;
        mf;
        chk(transmission_alarm_rx, 1'h0);
        chk(irq, 1'h1);
        wr(8'h08, 32'h2);
        @(negedge aclk);
        chk(irq, 1'h0);
        @(posedge aclk);
        {line_sync_state, lt_req, lt_alarm} <= 3'h7;
        mf;
        chk({user_activation_request_rx, transmission_alarm_rx}, 2'h3);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {d_maint_local, b1_maint_local, b2_maint_local, user_activation_request_signal, user_sync_frame_signal} = 5'h0;
        {terminal_sync_state_signal, line_sync_state, lt_req, lt_alarm} = 4'hF;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        s_regs;
        s_power;
        s_unused;
        s_test_mode;
        s_start_activity;
        s_receive;
        tally_and_finish;
    end
endmodule // omb_overhead_maint_test
`default_nettype wire
